// ---- design/dscw_top.sv ----
// Control and status word of the eight-channel half-bridge driver
`timescale 1ns/1ps
`include "dscw_cfg.svh"
module dscw_top (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic i_wr_en,
   input wire logic [31:0] i_wr_data,
   input wire logic i_rd_en,
   input wire logic i_comm_error,
   input wire logic i_overtemp,
   input wire logic i_undervoltage,
   input wire logic [7:0] i_ch_overcurrent,
   input wire logic [7:0] i_ch_open_load,
   input wire logic [7:0] i_ch_hit_fail,
   input wire logic [7:0] i_ch_plunger_fault,
   output logic [31:0] o_rd_data,
   output logic o_fault_n,
   output logic o_osc_freq_select,
   output logic o_active,
   output logic [7:0] o_ch_on,
   output logic [7:0] o_pair_modes,
   output dscw_pkg::dscw_dir_t o_hb_dir_hi,
   output dscw_pkg::dscw_dir_t o_hb_dir_mid,
   output logic o_ch7_uses_six_config,
   output logic o_ch5_uses_four_config
);
   import dscw_pkg::*;

   // Effective on bits {upper, lower} of one pair
   function automatic logic [1:0] pair_drive(input logic [1:0] mode, input logic [1:0] on,
                                             input logic upper_leads);
      logic lead;
      lead = upper_leads ? on[1] : on[0];
      case (dscw_pair_mode_t'(mode))
         DSCW_PM_INDEP: pair_drive = on;
         DSCW_PM_PARALLEL: pair_drive = {lead, lead};
         default: pair_drive = 2'h0;
      endcase
   endfunction

   // Bridge direction of one pair, Hi-Z unless in H-bridge mode
   function automatic dscw_dir_t pair_dir(input logic [1:0] mode, input logic [1:0] on);
      if (dscw_pair_mode_t'(mode) == DSCW_PM_HBRIDGE) begin
         pair_dir = dscw_dir_t'(on);
      end else begin
         pair_dir = DSCW_DIR_HIZ;
      end
   endfunction

   // Pair runs under its lower channel's configuration
   function automatic logic pair_shares_cfg(input logic [1:0] mode);
      pair_shares_cfg = (dscw_pair_mode_t'(mode) == DSCW_PM_PARALLEL) ||
                        (dscw_pair_mode_t'(mode) == DSCW_PM_HBRIDGE);
   endfunction

   // Strobe aimed at the control word
   function automatic logic word_hit(input logic strobe, input logic [7:0] addr);
      word_hit = strobe && (addr == `DSCW_ADDR_STATUS);
   endfunction

   logic [33:0] fault_sync;
   logic ovt_s;
   logic uv_s;
   logic [7:0] oc_s;
   logic [7:0] ol_s;
   logic [7:0] hh_s;
   logic [7:0] dpm_s;

   dscw_sync #(.WIDTH(34)) u_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async({i_overtemp, i_undervoltage, i_ch_overcurrent, i_ch_open_load,
                i_ch_hit_fail, i_ch_plunger_fault}),
      .o_sync(fault_sync)
   );

   assign {ovt_s, uv_s, oc_s, ol_s, hh_s, dpm_s} = fault_sync;

   // Register state
   logic [7:0] on_r;
   logic [7:0] on_nxt;
   logic [6:0] mask_r;
   logic [6:0] mask_nxt;
   logic freq_r;
   logic freq_nxt;
   logic [7:0] pm_r;
   logic [7:0] pm_nxt;
   logic [6:0] flag_r;
   logic [6:0] flag_nxt;
   logic active_r;
   logic active_nxt;
   logic [31:0] rd_data_r;
   logic [31:0] rd_data_nxt;
   logic wr_hit;
   logic rd_hit;
   logic [6:0] flag_set;
   logic [31:0] word;

   assign wr_hit = word_hit(i_wr_en, i_addr);
   assign rd_hit = word_hit(i_rd_en, i_addr);

   // Summary flags in order 7 down to 1
   assign flag_set = {ovt_s, |oc_s, |ol_s, |hh_s, |dpm_s, i_comm_error, uv_s};

   assign word = {on_r, mask_r, freq_r, pm_r, flag_r, active_r};

   // Each pair mode field is locked while either channel of its pair is on
   genvar p;
   generate
      for (p = 0; p < 4; p++) begin : g_pair_lock
         assign pm_nxt[2*p+1:2*p] = (wr_hit && (on_r[2*p+1:2*p] == 2'h0))
                                    ? i_wr_data[`DSCW_PM_LSB+2*p+1:`DSCW_PM_LSB+2*p]
                                    : pm_r[2*p+1:2*p];
      end
   endgenerate

   always_comb begin
      on_nxt = on_r;
      mask_nxt = mask_r;
      freq_nxt = freq_r;
      active_nxt = active_r;
      rd_data_nxt = rd_data_r;
      if (wr_hit) begin
         on_nxt = i_wr_data[`DSCW_ON_MSB:`DSCW_ON_LSB];
         mask_nxt = i_wr_data[`DSCW_MASK_MSB:`DSCW_MASK_LSB];
         freq_nxt = i_wr_data[`DSCW_FREQ_BIT];
         active_nxt = i_wr_data[`DSCW_ACTIVE_BIT];
      end
      if (rd_hit) begin
         rd_data_nxt = word;
      end
      // Read clears, a new event in the same cycle still sets
      flag_nxt = (rd_hit ? 7'h00 : flag_r) | flag_set;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         on_r <= `DSCW_ON_RESET;
         mask_r <= `DSCW_MASK_RESET;
         freq_r <= `DSCW_FREQ_RESET;
         pm_r <= `DSCW_PM_RESET;
         flag_r <= `DSCW_FLAG_RESET;
         active_r <= `DSCW_ACTIVE_RESET;
         rd_data_r <= 32'h0000_0000;
      end else begin
         on_r <= on_nxt;
         mask_r <= mask_nxt;
         freq_r <= freq_nxt;
         pm_r <= pm_nxt;
         flag_r <= flag_nxt;
         active_r <= active_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   // Output stage state
   logic [7:0] ch_on_r;
   logic [7:0] ch_on_nxt;
   dscw_dir_t dir_hi_r;
   dscw_dir_t dir_hi_nxt;
   dscw_dir_t dir_mid_r;
   dscw_dir_t dir_mid_nxt;
   logic cfg_six_r;
   logic cfg_six_nxt;
   logic cfg_four_r;
   logic cfg_four_nxt;
   logic fault_n_r;
   logic fault_n_nxt;
   logic [1:0] mode_hi;
   logic [1:0] mode_mid;

   assign mode_hi = pm_r[2*`DSCW_PAIR_HI+1:2*`DSCW_PAIR_HI];
   assign mode_mid = pm_r[2*`DSCW_PAIR_MID+1:2*`DSCW_PAIR_MID];

   always_comb begin
      ch_on_nxt = on_r;
      ch_on_nxt[7:6] = pair_drive(mode_hi, on_r[7:6], 1'b0);
      ch_on_nxt[5:4] = pair_drive(mode_mid, on_r[5:4], 1'b1);
      dir_hi_nxt = pair_dir(mode_hi, on_r[7:6]);
      dir_mid_nxt = pair_dir(mode_mid, on_r[5:4]);
      cfg_six_nxt = pair_shares_cfg(mode_hi);
      cfg_four_nxt = pair_shares_cfg(mode_mid);
      if (!active_r) begin
         ch_on_nxt = 8'h00;
         dir_hi_nxt = DSCW_DIR_HIZ;
         dir_mid_nxt = DSCW_DIR_HIZ;
      end
      // Masked sources stay off the active-low fault pin
      fault_n_nxt = ~|(flag_r & ~mask_r);
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ch_on_r <= 8'h00;
         dir_hi_r <= DSCW_DIR_HIZ;
         dir_mid_r <= DSCW_DIR_HIZ;
         cfg_six_r <= 1'b0;
         cfg_four_r <= 1'b0;
         fault_n_r <= 1'b1;
      end else begin
         ch_on_r <= ch_on_nxt;
         dir_hi_r <= dir_hi_nxt;
         dir_mid_r <= dir_mid_nxt;
         cfg_six_r <= cfg_six_nxt;
         cfg_four_r <= cfg_four_nxt;
         fault_n_r <= fault_n_nxt;
      end
   end

   assign o_rd_data = rd_data_r;
   assign o_fault_n = fault_n_r;
   assign o_osc_freq_select = freq_r;
   assign o_active = active_r;
   assign o_ch_on = ch_on_r;
   assign o_pair_modes = pm_r;
   assign o_hb_dir_hi = dir_hi_r;
   assign o_hb_dir_mid = dir_mid_r;
   assign o_ch7_uses_six_config = cfg_six_r;
   assign o_ch5_uses_four_config = cfg_four_r;
endmodule

// ---- design/dscw_cfg.svh ----
// Offsets, field positions, reset values and frequencies of the driver control word
`ifndef DSCW_CFG_SVH
`define DSCW_CFG_SVH

`define DSCW_ADDR_STATUS 8'h00
`define DSCW_ON_MSB 31
`define DSCW_ON_LSB 24
`define DSCW_MASK_MSB 23
`define DSCW_MASK_LSB 17
`define DSCW_FREQ_BIT 16
`define DSCW_PM_MSB 15
`define DSCW_PM_LSB 8
`define DSCW_FLAG_MSB 7
`define DSCW_FLAG_LSB 1
`define DSCW_ACTIVE_BIT 0
`define DSCW_ON_RESET 8'h00
`define DSCW_MASK_RESET 7'h02
`define DSCW_FREQ_RESET 1'h0
`define DSCW_PM_RESET 8'h00
`define DSCW_FLAG_RESET 7'h01
`define DSCW_ACTIVE_RESET 1'h0
`define DSCW_OSC_FAST_KHZ 100
`define DSCW_OSC_SLOW_KHZ 80
`define DSCW_PAIR_HI 3
`define DSCW_PAIR_MID 2

`endif

// ---- design/dscw_pkg.sv ----
// Types shared by the driver control word logic
package dscw_pkg;
   typedef enum logic [1:0] {
      DSCW_PM_INDEP = 2'h0,
      DSCW_PM_PARALLEL = 2'h1,
      DSCW_PM_HBRIDGE = 2'h2,
      DSCW_PM_RSVD = 2'h3
   } dscw_pair_mode_t;

   typedef enum logic [1:0] {
      DSCW_DIR_HIZ = 2'h0,
      DSCW_DIR_FWD = 2'h1,
      DSCW_DIR_REV = 2'h2,
      DSCW_DIR_BRAKE = 2'h3
   } dscw_dir_t;
endpackage

// ---- design/dscw_sync.sv ----
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module dscw_sync #(
   parameter int WIDTH = 34
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_nxt;

   always_comb begin
      meta_nxt = i_async;
      sync_nxt = meta_r;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign o_sync = sync_r;
endmodule

// ---- test/dscw_top_monitor.sv ----
// Port-level checks of the driver control word
`timescale 1ns/1ps
module dscw_mon (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic i_wr_en,
   input wire logic [31:0] i_wr_data,
   input wire logic i_rd_en,
   input wire logic [31:0] o_rd_data,
   input wire logic o_fault_n,
   input wire logic o_osc_freq_select,
   input wire logic o_active,
   input wire logic [7:0] o_ch_on,
   input wire logic [7:0] o_pair_modes,
   input wire logic o_ch7_uses_six_config,
   input wire logic o_ch5_uses_four_config
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   logic w0;
   assign w0 = i_wr_en && i_addr == 8'h00;
   property p_fq;
      w0 |=> {o_osc_freq_select, o_active} == {$past(i_wr_data[16]), $past(i_wr_data[0])};
   endproperty
   a_fq: assert property (p_fq) else $error("freq or active bit");
   property p_off; !o_active |=> o_ch_on == 8'h00; endproperty
   a_off: assert property (p_off) else $error("standby output on");
   property p_on;
      w0 && i_wr_data[15:8] == 8'h00 && o_pair_modes == 8'h00 && i_wr_data[0]
         |=> ##1 o_ch_on == $past(i_wr_data[31:24], 2);
   endproperty
   a_on: assert property (p_on) else $error("channel on bits");
   property p_ph; o_pair_modes[7:6] == 2'h1 |=> o_ch_on[7] == o_ch_on[6]; endproperty
   a_ph: assert property (p_ph) else $error("pair hi parallel");
   property p_hh;
      o_pair_modes[7:6] == 2'h2 |=> o_ch_on[7:6] == 2'h0 && o_ch7_uses_six_config;
   endproperty
   a_hh: assert property (p_hh) else $error("pair hi bridge");
   property p_pm;
      o_pair_modes[5:4] == 2'h1 |=> o_ch_on[5] == o_ch_on[4] && o_ch5_uses_four_config;
   endproperty
   a_pm: assert property (p_pm) else $error("pair mid parallel");
   property p_ur; i_rd_en && i_addr != 8'h00 |=> $stable(o_rd_data); endproperty
   a_ur: assert property (p_ur) else $error("unmapped read");
   property p_uv; $fell(i_rst) |-> ##[0:2] !o_fault_n; endproperty
   a_uv: assert property (p_uv) else $error("reset fault pin");
endmodule
bind dscw_top dscw_mon dscw_mon_i (.i_clock, .i_rst, .i_addr, .i_wr_en, .i_wr_data,
   .i_rd_en, .o_rd_data, .o_fault_n, .o_osc_freq_select, .o_active, .o_ch_on,
   .o_pair_modes, .o_ch7_uses_six_config, .o_ch5_uses_four_config);

// ---- test/dscw_host.sv ----
// Host model issuing register strobes
`timescale 1ns/1ps
module dscw_host (
   input wire logic i_clock,
   input wire logic [31:0] i_rd_data,
   output logic [7:0] o_addr,
   output logic o_wr_en,
   output logic [31:0] o_wr_data,
   output logic o_rd_en
);
   initial begin
      o_addr = 8'h00;
      o_wr_en = 1'b0;
      o_wr_data = 32'h0;
      o_rd_en = 1'b0;
   end
   task automatic wr(input logic [31:0] d);
      @(posedge i_clock);
      o_addr <= 8'h00;
      o_wr_en <= 1'b1;
      o_wr_data <= d;
      @(posedge i_clock);
      o_wr_en <= 1'b0;
      o_wr_data <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clock);
      o_addr <= a;
      o_rd_en <= 1'b1;
      @(posedge i_clock);
      o_rd_en <= 1'b0;
      #1;
      d = i_rd_data;
   endtask
endmodule

// ---- test/tb_driver_status_control_word.sv ----
// Self-checking bench for the driver control word
`timescale 1ns/1ps
module tb_driver_status_control_word;
   import dscw_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr, rd, fault_n, freq, act;
   logic [7:0] addr, on, pm;
   logic [31:0] wdat, rdat, v;
   logic c6, c4;
   logic [34:0] src = 35'h0;
   // Pulse position per flag, channel differs per source
   int sh [7] = '{0, 1, 2, 15, 21, 33, 34};
   dscw_dir_t dh, dm;
   int n_fail = 0;
   int n_tests = 0;
   initial forever #50 clk = ~clk;
   dscw_host dscw_host_i (.i_clock(clk), .i_rd_data(rdat), .o_addr(addr), .o_wr_en(wr),
      .o_wr_data(wdat), .o_rd_en(rd));
   dscw_top dscw_top_i (.i_clock(clk), .i_rst(rst), .i_addr(addr), .i_wr_en(wr),
      .i_wr_data(wdat), .i_rd_en(rd), .i_comm_error(src[1]), .i_overtemp(src[34]),
      .i_undervoltage(src[0]), .i_ch_overcurrent(src[33:26]),
      .i_ch_open_load(src[25:18]), .i_ch_hit_fail(src[17:10]),
      .i_ch_plunger_fault(src[9:2]), .o_rd_data(rdat), .o_fault_n(fault_n),
      .o_osc_freq_select(freq), .o_active(act), .o_ch_on(on), .o_pair_modes(pm),
      .o_hb_dir_hi(dh), .o_hb_dir_mid(dm), .o_ch7_uses_six_config(c6),
      .o_ch5_uses_four_config(c4));
   task automatic chk(input string n, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic rchk(input logic [31:0] e);
      dscw_host_i.rd(8'h00, v);
      chk("word", v, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rchk(32'h0004_0002);
      rchk(32'h0004_0000);
      $display("test reset done");
      dscw_host_i.wr(32'h0001_9001);
      rchk(32'h0001_9001);
      chk("freq", 32'(freq), 32'h1);
      dscw_host_i.wr(32'h7001_9001);
      cyc(2);
      chk("on", 32'(on), 32'h30);
      chk("dir", 32'(dh), 32'(DSCW_DIR_FWD));
      dscw_host_i.wr(32'h7001_0001);
      dscw_host_i.wr(32'h0001_0001);
      rchk(32'h0001_9001);
      for (int i = 0; i < 2; i++) dscw_host_i.wr(32'h0f01_00ff);
      rchk(32'h0f01_0001);
      chk("on", 32'(on), 32'h0f);
      chk("cfg", 32'({c6, c4}), 32'h0);
      $display("test pair lock done");
      dscw_host_i.wr(32'hff01_4000);
      cyc(2);
      chk("on", 32'(on), 32'h0);
      $display("test standby done");
      for (int k = 0; k < 7; k++) begin
         @(posedge clk) src <= 35'(35'h1 << sh[k]);
         @(posedge clk) src <= 35'h0;
         cyc(5);
         chk("fault_n", 32'(fault_n), 32'h0);
         rchk(32'hff01_4000 | (32'h2 << k));
      end
      $display("test fault flags done");
      dscw_host_i.wr(32'hfffe_4000);
      @(posedge clk) src <= 35'h4_0000_0000;
      @(posedge clk) src <= 35'h0;
      cyc(5);
      chk("fault_n", 32'(fault_n), 32'h1);
      rchk(32'hfffe_4080);
      dscw_host_i.rd(8'h01, v);
      chk("unmapped", v, 32'hfffe_4080);
      $display("test mask done");
      dscw_host_i.wr(32'h0001_0001);
      dscw_host_i.wr(32'h0001_6001);
      dscw_host_i.wr(32'ha501_6001);
      cyc(2);
      chk("pm", 32'(pm), 32'h60);
      chk("act", 32'(act), 32'h1);
      chk("on", 32'(on), 32'h05);
      chk("dir_mid", 32'(dm), 32'(DSCW_DIR_REV));
      chk("dir_hi", 32'(dh), 32'(DSCW_DIR_HIZ));
      chk("cfg", 32'({c6, c4}), 32'h3);
      dscw_host_i.wr(32'h7001_6001);
      cyc(2);
      chk("on", 32'(on), 32'hc0);
      chk("dir_mid", 32'(dm), 32'(DSCW_DIR_BRAKE));
      dscw_host_i.wr(32'h0001_f001);
      dscw_host_i.wr(32'hf001_f001);
      cyc(2);
      chk("on", 32'(on), 32'h0);
      chk("cfg", 32'({c6, c4}), 32'h0);
      rchk(32'hf001_f001);
      $display("test bridge done");
      tally_and_finish;
   end
endmodule
